//--- hw/meter_pkg.sv
// Constants and types shared by the meter serial command port
package meter_pkg;
	// ****************************************
	// Widths and counts
	// ****************************************
	localparam int unsigned REG_W = 24;
	localparam int unsigned WR_BYTES = 3;
	localparam int unsigned TX_BITS = 32;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam logic [1:0] PULSE_ENABLES = 2'h2;
	localparam logic [4:0] K_ZERO_RATIO = 5'h10;
	// ****************************************
	// Register indices and config fields
	// ****************************************
	localparam logic [4:0] IDX_CONFIG = 5'h00;
	localparam logic [4:0] IDX_STATUS = 5'h0f;
	localparam logic [4:0] IDX_MASK = 5'h1a;
	localparam logic [4:0] IDX_PAGE = 5'h1f;
	localparam int unsigned CFG_K_LSB = 0;
	localparam int unsigned CFG_K_W = 4;
	localparam int unsigned CFG_INV_BIT = 4;
	localparam int unsigned CFG_PULSE_BIT = 5;
	// ****************************************
	// Reset values and transmit pad byte
	// ****************************************
	localparam logic [23:0] CONFIG_RST = 24'h000001;
	localparam logic [23:0] STATUS_RST = 24'h000000;
	localparam logic [23:0] MASK_RST = 24'h000000;
	localparam logic [23:0] PAGE_RST = 24'h000000;
	localparam logic [7:0] TX_PAD = 8'h00;
	// ****************************************
	// Command encodings
	// ****************************************
	localparam logic [7:0] START_MASK = 8'hf7;
	localparam logic [7:0] START_VAL = 8'he0;
	localparam int unsigned START_CONT_BIT = 3;
	localparam logic [7:0] POWER_MASK = 8'hcf;
	localparam logic [7:0] POWER_VAL = 8'h80;
	localparam int unsigned PWR_SEL_LSB = 4;
	localparam logic [7:0] REG_MASK = 8'h81;
	localparam logic [7:0] REG_VAL = 8'h00;
	localparam logic [7:0] SYNC_MASK = 8'hfe;
	localparam logic [7:0] SYNC_VAL = 8'hfe;
	localparam logic [31:0] RESYNC_PATTERN = 32'hfffffffe;
	localparam logic [1:0] PWR_RESET = 2'h0;
	localparam logic [1:0] PWR_SLEEP = 2'h1;
	localparam logic [1:0] PWR_UP = 2'h2;
	localparam logic [1:0] PWR_STANDBY = 2'h3;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		INSTR_SINGLE = 3'b000,
		INSTR_CONT = 3'b001,
		INSTR_RESET = 3'b010,
		INSTR_SLEEP = 3'b011,
		INSTR_POWER_UP = 3'b100,
		INSTR_STANDBY = 3'b101
	} instr_t;
	typedef struct packed {
		instr_t code;
	} instr_word_t;
	typedef struct packed {
		logic top;
		logic write;
		logic [4:0] reg_index;
		logic low;
	} reg_cmd_t;
	typedef enum logic {
		DEC_CMD = 1'b0,
		DEC_WDATA = 1'b1
	} dec_state_t;
endpackage

//--- hw/cmd_fifo.sv
// Instruction FIFO between the command decoder and the datapath
`timescale 1ns/100ps
module cmd_fifo #(
	parameter int WIDTH = 3,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// Filling side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Draining side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;
	assign in_ready_o = count_q != (AW+1)'(DEPTH);
	assign out_valid_o = count_q != '0;
	assign out_data_o = mem_q[rd_ptr_q];

	always_ff @(posedge clk_sys_i) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule // cmd_fifo

//--- hw/meter_serial_command_port.sv
// Serial command port, event pin and clock divider of the meter
`timescale 1ns/100ps
module meter_serial_command_port #(
	parameter int FIFO_DEPTH = meter_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// Serial link
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic serial_in_i,
	output logic serial_out_o,
	// Event pin and divided clock
	output logic event_o,
	output logic divided_clock_o,
	// Datapath side
	input wire logic [23:0] status_set_i,
	output logic instr_valid_o,
	input wire logic instr_ready_i,
	output meter_pkg::instr_word_t instr_word_o,
	output logic abort_o,
	output logic sleep_o,
	output logic standby_o
);
	function automatic logic is_reg_cmd(input logic [7:0] b);
		is_reg_cmd = (b & meter_pkg::REG_MASK) == meter_pkg::REG_VAL;
	endfunction

	function automatic meter_pkg::instr_t power_code(input logic [1:0] sel);
		unique case (sel)
			meter_pkg::PWR_RESET: power_code = meter_pkg::INSTR_RESET;
			meter_pkg::PWR_SLEEP: power_code = meter_pkg::INSTR_SLEEP;
			meter_pkg::PWR_UP: power_code = meter_pkg::INSTR_POWER_UP;
			meter_pkg::PWR_STANDBY: power_code = meter_pkg::INSTR_STANDBY;
		endcase
	endfunction

	// ****************************************
	// Serial edges and receive shift
	// ****************************************
	logic sclk_prev_q;
	logic [2:0] bit_cnt_q;
	logic [31:0] rx_hist_q;
	wire sclk_rise = !cs_n_i && sclk_i && !sclk_prev_q;
	wire sclk_fall = !cs_n_i && !sclk_i && sclk_prev_q;
	wire [31:0] rx_next = {rx_hist_q[30:0], serial_in_i};
	wire resync_hit = sclk_rise && (rx_next == meter_pkg::RESYNC_PATTERN);
	wire byte_done = sclk_rise && (bit_cnt_q == 3'h7) && !resync_hit;
	wire [7:0] rx_byte = rx_next[7:0];

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sclk_prev_q <= 1'b0;
			bit_cnt_q <= 3'h0;
			rx_hist_q <= 32'h00000000;
		end else begin
			sclk_prev_q <= sclk_i;
			if (cs_n_i || resync_hit) begin
				bit_cnt_q <= 3'h0;
			end else if (sclk_rise) begin
				bit_cnt_q <= bit_cnt_q + 3'h1;
			end
			if (sclk_rise) begin
				rx_hist_q <= rx_next;
			end
		end
	end

	// ****************************************
	// Command decode
	// ****************************************
	meter_pkg::dec_state_t dec_q;
	logic [1:0] wr_cnt_q;
	logic [4:0] wr_idx_q;
	logic [15:0] wr_data_q;
	logic sleep_q;
	logic standby_q;
	logic [23:0] config_q;
	logic [23:0] status_q;
	logic [23:0] mask_q;
	logic [23:0] page_q;
	wire meter_pkg::reg_cmd_t cmd = rx_byte;
	wire cmd_is_reg = is_reg_cmd(rx_byte);
	wire cmd_is_sync = (rx_byte & meter_pkg::SYNC_MASK) == meter_pkg::SYNC_VAL;
	wire cmd_is_start = (rx_byte & meter_pkg::START_MASK) == meter_pkg::START_VAL;
	wire cmd_is_power = (rx_byte & meter_pkg::POWER_MASK) == meter_pkg::POWER_VAL;
	wire in_cmd = byte_done && (dec_q == meter_pkg::DEC_CMD);
	wire new_read = in_cmd && cmd_is_reg && !cmd.write;
	wire new_write = in_cmd && cmd_is_reg && cmd.write;
	wire new_instr = in_cmd && !cmd_is_sync && (cmd_is_start || cmd_is_power);
	wire [1:0] pwr_sel = rx_byte[meter_pkg::PWR_SEL_LSB +: 2];
	wire cont_sel = rx_byte[meter_pkg::START_CONT_BIT];
	wire meter_pkg::instr_t new_code = cmd_is_start ?
		(cont_sel ? meter_pkg::INSTR_CONT : meter_pkg::INSTR_SINGLE) :
		power_code(pwr_sel);
	wire powered_down = sleep_q || standby_q;
	wire regs_clr = new_instr && cmd_is_power && ((pwr_sel == meter_pkg::PWR_RESET) ||
		((pwr_sel == meter_pkg::PWR_UP) && powered_down));
	wire wr_commit = byte_done && (dec_q == meter_pkg::DEC_WDATA) &&
		(wr_cnt_q == 2'(meter_pkg::WR_BYTES - 1));
	wire [23:0] wr_word = {wr_data_q, rx_byte};
	wire page_zero = page_q == meter_pkg::PAGE_RST;
	wire wr_config = wr_commit && page_zero && (wr_idx_q == meter_pkg::IDX_CONFIG);
	wire wr_status = wr_commit && page_zero && (wr_idx_q == meter_pkg::IDX_STATUS);
	wire wr_mask = wr_commit && page_zero && (wr_idx_q == meter_pkg::IDX_MASK);
	wire wr_page = wr_commit && (wr_idx_q == meter_pkg::IDX_PAGE);

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dec_q <= meter_pkg::DEC_CMD;
			wr_cnt_q <= 2'h0;
			wr_idx_q <= 5'h00;
			wr_data_q <= 16'h0000;
		end else if (cs_n_i || resync_hit) begin
			dec_q <= meter_pkg::DEC_CMD;
		end else if (byte_done) begin
			unique case (dec_q)
				meter_pkg::DEC_CMD: begin
					if (new_write) begin
						dec_q <= meter_pkg::DEC_WDATA;
						wr_cnt_q <= 2'h0;
						wr_idx_q <= cmd.reg_index;
					end
				end
				meter_pkg::DEC_WDATA: begin
					wr_data_q <= {wr_data_q[7:0], rx_byte};
					wr_cnt_q <= wr_cnt_q + 2'h1;
					if (wr_commit) begin
						dec_q <= meter_pkg::DEC_CMD;
					end
				end
			endcase
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	wire [23:0] status_clr = wr_status ? wr_word : 24'h000000;
	wire [23:0] status_d = (status_q & ~status_clr) | status_set_i;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			config_q <= meter_pkg::CONFIG_RST;
			status_q <= meter_pkg::STATUS_RST;
			mask_q <= meter_pkg::MASK_RST;
			page_q <= meter_pkg::PAGE_RST;
		end else if (regs_clr) begin
			config_q <= meter_pkg::CONFIG_RST;
			status_q <= meter_pkg::STATUS_RST;
			mask_q <= meter_pkg::MASK_RST;
			page_q <= meter_pkg::PAGE_RST;
		end else begin
			status_q <= status_d;
			if (wr_config) begin
				config_q <= wr_word;
			end
			if (wr_mask) begin
				mask_q <= wr_word;
			end
			if (wr_page) begin
				page_q <= wr_word;
			end
		end
	end

	// ****************************************
	// Read data and transmit shift
	// ****************************************
	logic [31:0] tx_q;
	logic [5:0] tx_bits_q;
	logic serial_out_q;
	wire [4:0] rd_idx = cmd.reg_index;
	wire [23:0] rd_word = !page_zero ? 24'h000000 :
		(rd_idx == meter_pkg::IDX_CONFIG) ? config_q :
		(rd_idx == meter_pkg::IDX_STATUS) ? status_q :
		(rd_idx == meter_pkg::IDX_MASK) ? mask_q : 24'h000000;
	wire tx_msb = tx_q[31];

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_q <= 32'h00000000;
			tx_bits_q <= 6'h00;
			serial_out_q <= 1'b0;
		end else if (cs_n_i) begin
			tx_bits_q <= 6'h00;
			serial_out_q <= 1'b0;
		end else if (new_read) begin
			tx_q <= {rd_word, meter_pkg::TX_PAD};
			tx_bits_q <= 6'(meter_pkg::TX_BITS);
		end else if (sclk_fall) begin
			if (tx_bits_q != 6'h00) begin
				serial_out_q <= tx_msb;
				tx_q <= {tx_q[30:0], 1'b0};
				tx_bits_q <= tx_bits_q - 6'h01;
			end else begin
				serial_out_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Instruction hand-off and power state
	// ****************************************
	logic pend_valid_q;
	meter_pkg::instr_word_t pend_q;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [$bits(meter_pkg::instr_word_t)-1:0] fifo_out_data;
	logic instr_valid_q;
	meter_pkg::instr_word_t instr_word_q;
	logic abort_q;
	wire fifo_take = fifo_out_valid && (!instr_valid_q || instr_ready_i);

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pend_valid_q <= 1'b0;
			pend_q <= '{code: meter_pkg::INSTR_SINGLE};
			abort_q <= 1'b0;
		end else begin
			abort_q <= new_instr;
			if (new_instr) begin
				pend_valid_q <= 1'b1;
				pend_q <= '{code: new_code};
			end else if (fifo_in_ready) begin
				pend_valid_q <= 1'b0;
			end
		end
	end

	cmd_fifo #(
		.WIDTH($bits(meter_pkg::instr_word_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.in_valid_i(pend_valid_q),
		.in_ready_o(fifo_in_ready),
		.in_data_i(pend_q),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_take),
		.out_data_o(fifo_out_data)
	);

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			instr_valid_q <= 1'b0;
			instr_word_q <= '{code: meter_pkg::INSTR_SINGLE};
		end else if (fifo_take) begin
			instr_valid_q <= 1'b1;
			instr_word_q <= meter_pkg::instr_word_t'(fifo_out_data);
		end else if (instr_ready_i) begin
			instr_valid_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sleep_q <= 1'b0;
			standby_q <= 1'b0;
		end else if (new_instr && cmd_is_power) begin
			unique case (pwr_sel)
				meter_pkg::PWR_SLEEP: begin
					sleep_q <= 1'b1;
					standby_q <= 1'b0;
				end
				meter_pkg::PWR_STANDBY: begin
					sleep_q <= 1'b0;
					standby_q <= 1'b1;
				end
				meter_pkg::PWR_RESET, meter_pkg::PWR_UP: begin
					sleep_q <= 1'b0;
					standby_q <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// Clock divider and event pin
	// ****************************************
	logic [4:0] div_cnt_q;
	logic divided_clock_q;
	logic irq_prev_q;
	logic [1:0] pulse_cnt_q;
	logic event_q;
	logic [5:0] plen_q;
	wire [3:0] k_field = config_q[meter_pkg::CFG_K_LSB +: meter_pkg::CFG_K_W];
	wire [4:0] div_ratio = (k_field == 4'h0) ? meter_pkg::K_ZERO_RATIO : {1'b0, k_field};
	wire divided_clock_en = div_cnt_q >= (div_ratio - 5'h01);
	wire cfg_inv = config_q[meter_pkg::CFG_INV_BIT];
	wire cfg_pulse = config_q[meter_pkg::CFG_PULSE_BIT];
	wire irq_any = |(status_q & mask_q);
	wire irq_rise = irq_any && !irq_prev_q;
	wire pulse_on = pulse_cnt_q != 2'h0;
	wire ev_active = cfg_pulse ? pulse_on : irq_any;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div_cnt_q <= 5'h00;
			divided_clock_q <= 1'b0;
		end else begin
			div_cnt_q <= divided_clock_en ? 5'h00 : div_cnt_q + 5'h01;
			divided_clock_q <= divided_clock_en;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_prev_q <= 1'b0;
			pulse_cnt_q <= 2'h0;
			event_q <= 1'b1;
		end else begin
			irq_prev_q <= irq_any;
			if (irq_rise) begin
				pulse_cnt_q <= meter_pkg::PULSE_ENABLES;
			end else if (divided_clock_en && pulse_on) begin
				pulse_cnt_q <= pulse_cnt_q - 2'h1;
			end
			event_q <= ~(ev_active ^ cfg_inv);
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			plen_q <= 6'h00;
		end else if (irq_rise) begin
			plen_q <= 6'h00;
		end else if (pulse_on && plen_q != 6'h3f) begin
			plen_q <= plen_q + 6'h01;
		end
	end

	assign serial_out_o = serial_out_q;
	assign event_o = event_q;
	assign divided_clock_o = divided_clock_q;
	assign instr_valid_o = instr_valid_q;
	assign instr_word_o = instr_word_q;
	assign abort_o = abort_q;
	assign sleep_o = sleep_q;
	assign standby_o = standby_q;

	// ****************************************
	// Assertions
	// ****************************************
	mask_gate_a: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		!cfg_pulse && !irq_any |=> event_o == !$past(cfg_inv)
	) else $error("event pin active with no masked status");
	level_high_a: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		!cfg_pulse && cfg_inv && irq_any |=> event_o
	) else $error("active-high level not driven");
	status_clear_a: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		wr_status && !regs_clr |=> (status_q & $past(wr_word) & ~$past(status_set_i)) == 24'h0
	) else $error("status bit not cleared by write of one");
	pulse_len_a: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		$fell(pulse_on) |-> plen_q >= {1'b0, div_ratio}
	) else $error("event pulse shorter than divided period");
	msb_first_a: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		sclk_fall && tx_bits_q != 6'h00 |=> serial_out_o == $past(tx_msb)
	) else $error("read data not shifted msb first");
	cs_idle_a: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		cs_n_i |=> bit_cnt_q == 3'h0 && dec_q == meter_pkg::DEC_CMD
	) else $error("bit counter not restarted by chip select");
	resync_align_a: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		resync_hit |=> bit_cnt_q == 3'h0 && dec_q == meter_pkg::DEC_CMD
	) else $error("sync sequence did not realign");
	write_commit_a: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		wr_config |=> config_q == $past(wr_word)
	) else $error("write data not committed");
	invalid_cmd_a: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		in_cmd && !cmd_is_reg && !cmd_is_start && !cmd_is_power |=> !abort_o
	) else $error("invalid command caused an action");
	read_keep_a: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		new_instr && tx_bits_q != 6'h00 |=> tx_bits_q == $past(tx_bits_q)
	) else $error("instruction disturbed read data");
	preempt_a: assert property (
		@(posedge clk_sys_i) disable iff (!rstn_i)
		new_instr |=> abort_o && pend_valid_q
	) else $error("instruction did not abort running command");
endmodule // meter_serial_command_port

//--- verification/host_link_model.sv
// Host model driving the serial command link
`timescale 1ns/100ps
module host_link_model (
	// Clock
	input wire logic clk_sys_i,
	// Serial link
	input wire logic serial_out_i,
	output logic cs_n_o,
	output logic sclk_o,
	output logic serial_in_o
);
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		serial_in_o = 1'b0;
	end
	// ****
	// Frame tasks
	// ****
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	task automatic open();
		cs_n_o = 1'b0;
		tick(2);
	endtask
	// Data line flips once released
	task automatic close();
		tick(2);
		cs_n_o = 1'b1;
		serial_in_o = ~serial_in_o;
		tick(2);
	endtask
	// Exchanges the top nb bits, clock phases of 3 cycles
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input int nb);
		rx = 8'h00;
		for (int i = 7; i > 7 - nb; i--) begin
			serial_in_o = tx[i];
			tick(3);
			rx[i] = serial_out_i;
			sclk_o = 1'b1;
			tick(3);
			sclk_o = 1'b0;
		end
	endtask
endmodule // host_link_model

//--- verification/meter_serial_command_port_test.sv
// Self-checking bench for the meter serial command port
`timescale 1ns/100ps
module test_meter_serial_command_port;
	logic clk_sys_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [23:0] status_set_i = 24'h000000;
	logic instr_ready_i = 1'b0;
	logic cs_n, sclk, serial_in, serial_out, event_o, divided_clock_o;
	logic instr_valid_o, abort_o, sleep_o, standby_o;
	meter_pkg::instr_word_t instr_word_o;
	int bad_count = 0;
	int comparisons = 0;
	int aborts = 0;
	int n, act, dcs;
	logic [7:0] r;
	logic [7:0] cmds [7] = '{8'he0, 8'he8, 8'h90, 8'ha0, 8'hb0, 8'ha0, 8'h80};
	logic [2:0] codes [7] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h4, 3'h2};
	always #20 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) if (abort_o === 1'b1) aborts++;
	host_link_model host_u (.clk_sys_i(clk_sys_i), .serial_out_i(serial_out), .cs_n_o(cs_n),
		.sclk_o(sclk), .serial_in_o(serial_in));
	meter_serial_command_port #(.FIFO_DEPTH(8)) dut_u (.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i), .cs_n_i(cs_n), .sclk_i(sclk), .serial_in_i(serial_in),
		.serial_out_o(serial_out), .event_o(event_o), .divided_clock_o(divided_clock_o),
		.status_set_i(status_set_i), .instr_valid_o(instr_valid_o),
		.instr_ready_i(instr_ready_i), .instr_word_o(instr_word_o), .abort_o(abort_o),
		.sleep_o(sleep_o), .standby_o(standby_o));
	// ****
	// Tasks
	// ****
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic wreg(input logic [4:0] idx, input logic [23:0] d);
		host_u.open();
		host_u.xfer({2'b01, idx, 1'b0}, r, 8);
		for (int b = 2; b >= 0; b--) host_u.xfer(d[b*8 +: 8], r, 8);
		host_u.close();
	endtask
	task automatic rc(input logic [4:0] idx, input logic [23:0] exp);
		logic [23:0] q;
		host_u.open();
		host_u.xfer({2'b00, idx, 1'b0}, r, 8);
		for (int b = 2; b >= 0; b--) host_u.xfer(8'hff, q[b*8 +: 8], 8);
		host_u.xfer(8'hfe, r, 8);
		host_u.close();
		chk(q, exp);
		chk(24'(r), 24'h0);
	endtask
	task automatic ins(input logic [7:0] cmd, input logic [2:0] code);
		n = aborts;
		host_u.open();
		host_u.xfer(cmd, r, 8);
		host_u.close();
		for (int k = 0; k < 20 && instr_valid_o !== 1'b1; k++) host_u.tick(1);
		chk(24'(aborts - n), 24'h1);
		chk(24'({instr_valid_o, instr_word_o.code}), 24'({1'b1, code}));
		chk(24'({sleep_o, standby_o}), 24'({code == 3'h3, code == 3'h5}));
		instr_ready_i = 1'b1;
		host_u.tick(1);
		instr_ready_i = 1'b0;
		host_u.tick(1);
		chk(24'(instr_valid_o), 24'h0);
	endtask
	task automatic pulse(input logic [23:0] s);
		status_set_i = s;
		host_u.tick(1);
		status_set_i = 24'h0;
		host_u.tick(3);
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		#4000000;
		bad_count++;
		final_report();
	end
	initial begin
		host_u.tick(8);
		rstn_i = 1'b1;
		host_u.tick(2);
		chk(24'({event_o, instr_valid_o, abort_o, sleep_o, standby_o, serial_out}), 24'h20);
		host_u.open();
		host_u.xfer(8'hff, r, 5);
		host_u.close();
		rc(meter_pkg::IDX_CONFIG, meter_pkg::CONFIG_RST);
		for (int i = 0; i < 7; i++) ins(cmds[i], codes[i]);
		n = aborts;
		host_u.xfer(8'h80, r, 8);
		host_u.open();
		host_u.xfer(8'h01, r, 8);
		host_u.xfer(8'hff, r, 8);
		host_u.close();
		chk(24'({instr_valid_o, 7'(aborts - n)}), 24'h0);
		wreg(meter_pkg::IDX_STATUS, 24'h0fffff);
		wreg(meter_pkg::IDX_MASK, 24'h5a0001);
		pulse(24'h000002);
		chk(24'(event_o), 24'h1);
		rc(meter_pkg::IDX_STATUS, 24'h2);
		wreg(meter_pkg::IDX_STATUS, 24'h2);
		rc(meter_pkg::IDX_STATUS, 24'h0);
		for (int m = 0; m < 4; m++) begin
			wreg(meter_pkg::IDX_CONFIG, 24'(m * 16 + 3));
			wreg(meter_pkg::IDX_STATUS, 24'h1);
			host_u.tick(4);
			chk(24'(event_o), 24'(!m[0]));
			status_set_i = 24'h1;
			host_u.tick(1);
			status_set_i = 24'h0;
			act = 0;
			dcs = 0;
			repeat (36) begin
				host_u.tick(1);
				act += (event_o === m[0]);
				dcs += (divided_clock_o === 1'b1);
			end
			chk(24'(dcs), 24'h0c);
			chk(24'(m > 1 ? act > 3 && act < 36 : act == 36), 24'h1);
		end
		rc(meter_pkg::IDX_STATUS, 24'h1);
		pulse(24'h000002);
		wreg(meter_pkg::IDX_STATUS, 24'h1);
		rc(meter_pkg::IDX_STATUS, 24'h2);
		wreg(meter_pkg::IDX_PAGE, 24'h1);
		wreg(meter_pkg::IDX_MASK, 24'h0);
		rc(meter_pkg::IDX_MASK, 24'h0);
		wreg(meter_pkg::IDX_PAGE, 24'h0);
		rc(meter_pkg::IDX_MASK, 24'h5a0001);
		host_u.open();
		host_u.xfer({2'b01, meter_pkg::IDX_MASK, 1'b0}, r, 8);
		host_u.xfer(8'h00, r, 8);
		host_u.xfer(8'h00, r, 8);
		host_u.close();
		rc(meter_pkg::IDX_MASK, 24'h5a0001);
		host_u.open();
		host_u.xfer(8'h00, r, 3);
		for (int b = 0; b < 4; b++) host_u.xfer({7'h7f, b != 3}, r, 8);
		host_u.xfer(8'h34, r, 8);
		host_u.xfer(8'he0, r, 8);
		chk(24'(r), 24'h5a);
		host_u.xfer(8'h00, r, 8);
		chk(24'(r), 24'h00);
		for (int b = 0; b < 3; b++) host_u.xfer(8'hff, r, 8);
		host_u.close();
		chk(24'(r), 24'h33);
		host_u.open();
		host_u.xfer(8'h80, r, 8);
		host_u.close();
		rc(meter_pkg::IDX_CONFIG, meter_pkg::CONFIG_RST);
		final_report();
	end
endmodule // test_meter_serial_command_port
